// File: testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic clk_i,
    // Command frame
    output logic cmd_valid_o,
    output logic [7:0] cmd_code_o,
    output logic cmd_read_o,
    output logic [7:0] cmd_len_o,
    input wire logic cmd_ready_i,
    input wire logic cmd_ignored_i,
    // Reply stream
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_last_i,
    output logic tx_ready_o
);
    logic [7:0] rx[$];
    logic stall = 1'b0;
    int last_at = 0;
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_read_o = 1'b0;
        cmd_len_o = 8'h00;
        tx_ready_o = 1'b0;
    end
    // Stalling toggles ready so each byte after a reply's first has to hold across a wait
    always @(posedge clk_i)
    begin
        if (tx_valid_i && tx_ready_o)
        begin
            rx.push_back(tx_data_i);
            if (tx_last_i)
                last_at = rx.size();
        end
        tx_ready_o <= stall ? ~tx_ready_o : 1'b1;
    end
    task automatic send(input logic [7:0] code, input logic rd, input logic [7:0] len,
                        output logic ign);
        int i;
        for (i = 0; i < 300 && cmd_ready_i !== 1'b1; i++)
            @(negedge clk_i);
        if (i == 300)
            tb.timeout_fail();
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o <= code;
        cmd_read_o <= rd;
        cmd_len_o <= len;
        @(negedge clk_i);
        ign = cmd_ignored_i;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        // Idle code and length lines carry junk, not the last frame
        cmd_code_o <= ~code;
        cmd_len_o <= ~len;
    endtask
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import idq_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cmd_valid, cmd_read, cmd_ready, cmd_ignored, tx_valid, tx_last, tx_ready;
    logic [7:0] cmd_code, cmd_len, tx_data;
    logic [127:0] serial_text = 128'h0;
    logic [4:0] serial_chars = 5'h00;
    logic [15:0] cam_ver = 16'h0, ee_fw = 16'h0, mcu_fw = 16'h0, fpga_fw = 16'h0, gain = 16'h0;
    logic [7:0] layout = 8'h00;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int cmp_count = 0;
    always #4 clk_i = ~clk_i;
    identity_query_responder uut (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid),
        .cmd_code_i(cmd_code), .cmd_read_i(cmd_read), .cmd_len_i(cmd_len),
        .cmd_ready_o(cmd_ready), .cmd_ignored_o(cmd_ignored), .serial_text_i(serial_text),
        .serial_chars_i(serial_chars), .cam_version_i(cam_ver), .eeprom_fw_i(ee_fw),
        .mcu_fw_i(mcu_fw), .fpga_fw_i(fpga_fw), .map_layout_code_i(layout),
        .min_gain_i(gain), .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_last_o(tx_last),
        .tx_ready_i(tx_ready));
    host_model host (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
        .cmd_read_o(cmd_read), .cmd_len_o(cmd_len), .cmd_ready_i(cmd_ready),
        .cmd_ignored_i(cmd_ignored), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_last_i(tx_last), .tx_ready_o(tx_ready));
    task automatic final_report();
        $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic timeout_fail();
        num_errors++;
        $display("Error %0t: wait limit reached", $time);
        final_report();
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Empty expectation means the frame must be dropped without a reply
    task automatic query(input logic [7:0] code, input logic rd, input logic [7:0] len);
        logic ign;
        host.send(code, rd, len, ign);
        check({7'h00, ign}, {7'h00, exp_q.size() == 0}, "drop status");
        @(negedge clk_i);
        check({7'h00, cmd_ready}, {7'h00, exp_q.size() == 0}, "ready after take");
        for (int i = 0; i < 200 && host.rx.size() < exp_q.size(); i++)
            @(posedge clk_i);
        if (host.rx.size() < exp_q.size())
            timeout_fail();
        repeat (4) @(posedge clk_i);
        check({7'h00, cmd_ready}, 8'h01, "ready when idle");
        check(8'(host.rx.size()), 8'(exp_q.size()), "reply length");
        foreach (exp_q[i])
            check(host.rx[i], exp_q[i], "reply byte");
        check(8'(host.last_at), 8'(exp_q.size()), "last marker");
        host.rx.delete();
        host.last_at = 0;
        exp_q.delete();
    endtask
    task automatic serial(input logic [4:0] chars);
        logic [127:0] text;
        text = 128'hFEDCBA98_76543210_0F1E2D3C_4B5A6978;
        serial_text <= text;
        serial_chars <= chars;
        host.stall = 1'b1;
        exp_q = {8'h04, 8'h00, 8'h10};
        for (int k = 0; k < 16; k++)
            exp_q.push_back(k < chars ? text[8*k+:8] : 8'h00);
        query(8'h04, 1'b1, 8'h10);
    endtask
    task automatic versions();
        logic [7:0] codes[4] = '{8'h05, 8'h06, 8'h40, 8'h41};
        logic [15:0] vals[4] = '{16'h1234, 16'h0567, 16'h2019, 16'h9876};
        cam_ver <= vals[0];
        ee_fw <= vals[1];
        mcu_fw <= vals[2];
        fpga_fw <= vals[3];
        layout <= 8'h3C;
        host.stall = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            exp_q = {codes[i], 8'h00, 8'h03, vals[i][7:0], vals[i][15:8], 8'h3C};
            query(codes[i], 1'b1, 8'h03);
        end
    endtask
    task automatic min_gain();
        gain <= 16'hBE7A;
        host.stall = 1'b1;
        exp_q = {8'h08, 8'h00, 8'h10, 8'h00, 8'h00, 8'h7A, 8'hBE};
        repeat (12) exp_q.push_back(8'h00);
        query(8'h08, 1'b1, 8'h10);
    endtask
    task automatic refusals();
        query(8'h04, 1'b0, 8'h10);
        query(8'h05, 1'b1, 8'h10);
        query(8'h08, 1'b1, 8'h03);
        query(8'h07, 1'b1, 8'h03);
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        serial(5'h05);
        serial(5'h10);
        min_gain();
        refusals();
        versions();
        final_report();
    end
endmodule

// File: verilog/identity_query_responder.sv
`timescale 1ns/1ps
module identity_query_responder
    import idq_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Parsed command frame
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic cmd_read_i,
    input wire logic [7:0] cmd_len_i,
    output logic cmd_ready_o,
    output logic cmd_ignored_o,
    // Identity sources
    input wire logic [8*TEXT_BYTES-1:0] serial_text_i,
    input wire logic [4:0] serial_chars_i,
    input wire logic [15:0] cam_version_i,
    input wire logic [15:0] eeprom_fw_i,
    input wire logic [15:0] mcu_fw_i,
    input wire logic [15:0] fpga_fw_i,
    input wire logic [7:0] map_layout_code_i,
    input wire logic [15:0] min_gain_i,
    // Reply byte stream
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic tx_last_o,
    input wire logic tx_ready_i
);

    typedef enum logic {ST_IDLE, ST_SEND} state_type;

    state_type state_r;
    logic [7:0] code_r;
    logic [7:0] len_r;
    logic [4:0] idx_r;
    logic [7:0] data_r;
    logic [8*TEXT_BYTES-1:0] text_r;
    logic [4:0] chars_r;
    logic [15:0] ver_r;
    logic [7:0] layout_r;
    logic [15:0] gain_r;

    wire logic take;
    wire logic known;
    wire logic match;
    wire logic start;
    wire logic beat;
    wire logic last;
    wire logic [4:0] next_idx;
    wire logic [4:0] pay_idx;
    wire logic [7:0] next_byte;
    wire logic [15:0] ver_sel;
    wire logic is_serial;
    wire logic is_gain;
    wire logic [7:0] pay_w [0:TEXT_BYTES-1];

    assign cmd_ready_o = (state_r == ST_IDLE);
    assign take = cmd_valid_i && cmd_ready_o;
    assign known = (query_len(cmd_code_i) != 8'h00);
    // Only a read with the exact length starts a reply
    assign match = known && cmd_read_i && (cmd_len_i == query_len(cmd_code_i));
    assign start = take && match;
    assign cmd_ignored_o = take && !match;

    assign ver_sel = (cmd_code_i == CODE_CAM_VER) ? cam_version_i :
                     (cmd_code_i == CODE_EE_FW) ? eeprom_fw_i :
                     (cmd_code_i == CODE_MCU_FW) ? mcu_fw_i :
                     fpga_fw_i;

    assign is_serial = (code_r == CODE_SERIAL);
    assign is_gain = (code_r == CODE_MIN_GAIN);

    // Payload built from the snapshot so a source change mid-reply cannot tear it
    genvar k;
    generate
        for (k = 0; k < TEXT_BYTES; k = k + 1)
        begin : g_pay
            wire logic [4:0] kk;
            wire logic [7:0] txt;
            wire logic [7:0] gn;
            wire logic [7:0] vr;
            assign kk = 5'(k);
            // Bytes from the character count on are zero; a full count leaves no terminator
            assign txt = (kk < chars_r) ? text_r[8*k +: 8] : TEXT_END;
            assign gn = (kk == PAY_GAIN_LO) ? gain_r[7:0] :
                        (kk == PAY_GAIN_HI) ? gain_r[15:8] :
                        RESERVED_FILL;
            assign vr = (kk == PAY_VER_LO) ? ver_r[7:0] :
                        (kk == PAY_VER_HI) ? ver_r[15:8] :
                        (kk == PAY_LAYOUT) ? layout_r :
                        RESERVED_FILL;
            assign pay_w[k] = is_serial ? txt : (is_gain ? gn : vr);
        end
    endgenerate

    assign beat = tx_valid_o && tx_ready_i;
    assign last = (idx_r == 5'(len_r + 8'(HDR_BYTES) - 8'h01));
    assign next_idx = 5'(idx_r + 5'h01);
    assign pay_idx = 5'(next_idx - HDR_BYTES);
    assign next_byte = (next_idx == IDX_FLAG) ? FLAG_REPLY :
                       (next_idx == IDX_LEN) ? len_r :
                       pay_w[pay_idx[3:0]];

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_r <= ST_IDLE;
            idx_r <= IDX_RST;
            data_r <= BYTE_RST;
        end
        else if (start)
        begin
            state_r <= ST_SEND;
            idx_r <= IDX_CODE;
            data_r <= cmd_code_i;
        end
        else if (beat)
        begin
            state_r <= last ? ST_IDLE : ST_SEND;
            idx_r <= last ? IDX_RST : next_idx;
            data_r <= last ? BYTE_RST : next_byte;
        end
    end

    // Snapshot taken only on a valid query; ignored frames touch nothing
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            code_r <= CODE_RST;
            len_r <= 8'h00;
            text_r <= '0;
            chars_r <= 5'h00;
            ver_r <= 16'h0000;
            layout_r <= 8'h00;
            gain_r <= 16'h0000;
        end
        else if (start)
        begin
            code_r <= cmd_code_i;
            len_r <= cmd_len_i;
            text_r <= serial_text_i;
            chars_r <= serial_chars_i;
            ver_r <= ver_sel;
            layout_r <= map_layout_code_i;
            gain_r <= min_gain_i;
        end
    end

    assign tx_valid_o = (state_r == ST_SEND);
    assign tx_data_o = data_r;
    assign tx_last_o = tx_valid_o && last;

    // Checks
    wire logic [4:0] chk_pay;
    assign chk_pay = 5'(idx_r - HDR_BYTES);

    // Second count of beats, kept apart from idx_r so a wrong index step shows up
    logic [4:0] beat_cnt_r;
    wire logic is_version;
    wire logic [4:0] text_end_idx;
    assign is_version = !is_serial && !is_gain;
    assign text_end_idx = 5'(HDR_BYTES + chars_r);

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            beat_cnt_r <= IDX_RST;
        end
        else if (start)
        begin
            beat_cnt_r <= IDX_RST;
        end
        else if (beat)
        begin
            beat_cnt_r <= 5'(beat_cnt_r + 5'h01);
        end
    end

    sequence s_accept;
        start;
    endsequence

    sequence s_header(logic [7:0] c);
        tx_valid_o && tx_data_o == c && idx_r == IDX_CODE;
    endsequence

    property p_code_echo;
        logic [7:0] c;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_accept, c = cmd_code_i) |=> s_header(c);
    endproperty

    a_reply_code_echo: assert property (p_code_echo)
        else $error("reply does not start with the request code");

    a_flag_byte_zero: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_valid_o && idx_r == IDX_FLAG |-> tx_data_o == 8'h00)
        else $error("direction byte of reply not zero");

    a_length_echo: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_valid_o && idx_r == IDX_LEN |-> tx_data_o == query_len(code_r))
        else $error("reply length field wrong");

    a_frame_size: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_last_o |-> idx_r == 5'(query_len(code_r) + 8'h02))
        else $error("reply payload byte count wrong");

    a_serial_text_end: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_valid_o && is_serial && idx_r >= HDR_BYTES |->
            tx_data_o == ((chk_pay < chars_r) ? text_r[8*chk_pay[3:0] +: 8] : 8'h00))
        else $error("serial text byte or terminator wrong");

    a_gain_bytes: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_valid_o && is_gain && idx_r == 5'(HDR_BYTES + PAY_GAIN_LO) |->
            tx_data_o == gain_r[7:0])
        else $error("minimum gain low byte misplaced");

    a_gain_high: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_valid_o && is_gain && idx_r == 5'(HDR_BYTES + PAY_GAIN_HI) |->
            tx_data_o == gain_r[15:8])
        else $error("minimum gain high byte misplaced");

    a_version_order: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_valid_o && is_version && idx_r == 5'(HDR_BYTES + PAY_VER_LO) && tx_ready_i |=>
            tx_data_o == ver_r[15:8] ##0 $past(tx_data_o) == ver_r[7:0])
        else $error("version bytes out of order");

    a_bad_frame_ignored: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        cmd_ignored_o |=> !tx_valid_o && $stable(code_r) && $stable(len_r))
        else $error("ignored frame started a reply or changed state");

    a_stall_holds: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(idx_r))
        else $error("reply byte changed while stalled");

    sequence s_last_beat;
        tx_last_o && tx_ready_i;
    endsequence

    sequence s_idle_again;
        !tx_valid_o && cmd_ready_o;
    endsequence

    a_return_idle: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        s_last_beat |=> s_idle_again)
        else $error("reply did not end after its last byte");

    a_index_step: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        beat && !last |=> tx_valid_o && idx_r == 5'($past(idx_r) + 5'h01))
        else $error("reply byte index did not advance by one");

    a_beat_count: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        s_last_beat |-> beat_cnt_r == 5'(query_len(code_r) + 8'h02))
        else $error("reply beat count wrong at last byte");

    a_count_tracks: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_valid_o |-> beat_cnt_r == idx_r)
        else $error("byte index and beat count disagree");

    a_text_terminator: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_valid_o && is_serial && chars_r < 5'(TEXT_BYTES) && idx_r == text_end_idx |->
            tx_data_o == TEXT_END)
        else $error("short serial text not terminated");

    a_text_full: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_valid_o && is_serial && chars_r >= 5'(TEXT_BYTES) && idx_r >= HDR_BYTES |->
            tx_data_o == text_r[8*chk_pay[3:0] +: 8])
        else $error("full serial text byte replaced");

    a_version_layout: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_valid_o && is_version && idx_r == 5'(HDR_BYTES + PAY_LAYOUT) |->
            tx_data_o == layout_r)
        else $error("layout code not in third version byte");

    a_gain_reserved: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_valid_o && is_gain && idx_r >= HDR_BYTES && chk_pay != PAY_GAIN_LO &&
            chk_pay != PAY_GAIN_HI |-> tx_data_o == RESERVED_FILL)
        else $error("reserved gain byte not filled");

    a_snapshot_taken: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        start |=> code_r == $past(cmd_code_i) && len_r == $past(cmd_len_i) &&
            gain_r == $past(min_gain_i) && layout_r == $past(map_layout_code_i))
        else $error("request not captured at acceptance");

    a_snapshot_held: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tx_valid_o |=> $stable(code_r) && $stable(len_r) && $stable(text_r) &&
            $stable(chars_r) && $stable(ver_r) && $stable(gain_r) && $stable(layout_r))
        else $error("captured sources changed during a reply");

endmodule

// File: verilog/idq_pkg.sv
// What this block does
// - Serial reply: 0x04, flag 0, 16 bytes
// - Short serial text ends with zero byte
// - Full sixteen-byte serial text sent unterminated
// - Camera version reply: 0x05, flag 0, 3
// - Version low BCD, high BCD, layout code
// - EEPROM firmware reply: 0x06, 3 bytes
// - Microcontroller firmware reply: 0x40, 3 bytes
// - FPGA firmware reply: 0x41, 3 bytes
// - Firmware payload: low, high, layout code
// - Minimum gain reply: 0x08, 16 bytes
// - Gain low in payload byte 2, high 3
// - Reserved gain bytes filled, host ignores them
package idq_pkg;

    localparam logic [7:0] CODE_SERIAL = 8'h04;
    localparam logic [7:0] CODE_CAM_VER = 8'h05;
    localparam logic [7:0] CODE_EE_FW = 8'h06;
    localparam logic [7:0] CODE_MIN_GAIN = 8'h08;
    localparam logic [7:0] CODE_MCU_FW = 8'h40;
    localparam logic [7:0] CODE_FPGA_FW = 8'h41;

    localparam logic [7:0] LEN_TEXT = 8'h10;
    localparam logic [7:0] LEN_VERSION = 8'h03;
    localparam logic [7:0] LEN_GAIN = 8'h10;
    localparam logic [7:0] FLAG_REPLY = 8'h00;
    localparam logic [7:0] RESERVED_FILL = 8'h00;
    localparam logic [7:0] TEXT_END = 8'h00;

    // Reply byte positions: header, then payload from index 0
    localparam logic [4:0] HDR_BYTES = 5'h03;
    localparam logic [4:0] IDX_CODE = 5'h00;
    localparam logic [4:0] IDX_FLAG = 5'h01;
    localparam logic [4:0] IDX_LEN = 5'h02;
    localparam logic [4:0] PAY_VER_LO = 5'h00;
    localparam logic [4:0] PAY_VER_HI = 5'h01;
    localparam logic [4:0] PAY_LAYOUT = 5'h02;
    localparam logic [4:0] PAY_GAIN_LO = 5'h02;
    localparam logic [4:0] PAY_GAIN_HI = 5'h03;
    localparam int TEXT_BYTES = 16;

    localparam logic [7:0] CODE_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [4:0] IDX_RST = 5'h00;

    // Expected length of a known query, zero for any other code
    function automatic logic [7:0] query_len(input logic [7:0] code);
        logic [7:0] len;
        len = 8'h00;
        unique case (code)
            CODE_SERIAL, CODE_MIN_GAIN:
                len = LEN_TEXT;
            CODE_CAM_VER, CODE_EE_FW, CODE_MCU_FW, CODE_FPGA_FW:
                len = LEN_VERSION;
            default:
                len = 8'h00;
        endcase
        return len;
    endfunction

endpackage
